/* core/epm_defines.svh */
// register offsets, reset values and field positions of the eight-bit port
// Functional notes
// R01 - eight pins, each individually input or output
// R02 - direction bit 1 drives, 0 listens
// R03 - output latch holds value driven on outputs
// R04 - read: latch where driving, pin level otherwise
// R05 - pin 7 carries serial transmit when enabled; code also needs smart_card_select low
// R06 - pin 7 feeds conversion trigger when selected
// R07 - pin 7 feeds interrupt 15 when selected
// R08 - software clears pin 7 direction for interrupt
// R09 - reset clears direction and latch, all inputs
`ifndef EPM_DEFINES_SVH
`define EPM_DEFINES_SVH
`define EPM_OFS_DIR 4'h0
`define EPM_OFS_LATCH 4'h4
`define EPM_RST_DIR 8'h00
`define EPM_RST_LATCH 8'h00
`define EPM_PIN_SEVEN 7
`define EPM_IDLE_LEVEL 1'b1
`endif

/* core/epm_pkg.sv */
// types of the eight-bit port with pin mux
package epm_pkg;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] latch;
        logic [7:0] pin_out;
        logic [7:0] pin_oe_n;
        logic irq15;
        logic trig;
        logic [31:0] rdata;
        logic waitreq;
    } epm_state_type;
endpackage

/* core/epm_port.sv */
// eight-bit gpio port, avalon slave, pin 7 function mux
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`include "epm_defines.svh"
module epm_port
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] address,
    input wire logic [3:0] byteenable,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_n,
    input wire logic serial_transmit_enable,
    input wire logic smart_card_select,
    input wire logic serial_transmit_out,
    input wire logic trigger_select_hi,
    input wire logic trigger_select_lo,
    input wire logic external_trigger_select,
    input wire logic irq15_source_select,
    output logic conversion_trigger_input,
    output logic ext_interrupt_15_input
);

////////////////////////////////////////////////////////////////////////////////

function automatic logic [7:0] port_view(input logic [7:0] latch, input logic [7:0] dir, input logic [7:0] pins);
    port_view = (latch & dir) | (pins & ~dir);
endfunction

epm_pkg::epm_state_type s_r;
epm_pkg::epm_state_type s_nxt;
logic tx_sel;
logic trg_sel;

assign tx_sel = serial_transmit_enable & ~smart_card_select;
assign trg_sel = trigger_select_hi & external_trigger_select & ~trigger_select_lo;

////////////////////////////////////////////////////////////////////////////////

always_comb
begin
    s_nxt = s_r;
    // one wait cycle per access; read data captured then
    if ((read || write) && s_r.waitreq)
    begin
        s_nxt.waitreq = 1'b0;
        s_nxt.rdata = 32'h00000000;
        if (read && address == `EPM_OFS_LATCH)
        begin
            s_nxt.rdata[7:0] = port_view(s_r.latch, s_r.dir, pin_in); // R04
        end
    end
    else if ((read || write) && !s_r.waitreq)
    begin
        s_nxt.waitreq = 1'b1;
        if (write && byteenable[0])
        begin
            unique case (address)
                `EPM_OFS_DIR: s_nxt.dir = writedata[7:0]; // R01
                `EPM_OFS_LATCH: s_nxt.latch = writedata[7:0]; // R03
                default: s_nxt.dir = s_r.dir;
            endcase
        end
    end
    s_nxt.pin_out = s_nxt.latch; // R03
    s_nxt.pin_oe_n = ~s_nxt.dir; // R02
    // serial transmit overrides the direction bit
    if (tx_sel)
    begin
        s_nxt.pin_out[`EPM_PIN_SEVEN] = serial_transmit_out; // R05
        s_nxt.pin_oe_n[`EPM_PIN_SEVEN] = 1'b0; // R05
    end
    // idle high: both inputs are active low
    s_nxt.trig = trg_sel ? pin_in[`EPM_PIN_SEVEN] : `EPM_IDLE_LEVEL; // R06
    s_nxt.irq15 = irq15_source_select ? pin_in[`EPM_PIN_SEVEN] : `EPM_IDLE_LEVEL; // R07
end

always_ff @(posedge core_clk or posedge rst)
begin
    if (rst)
    begin
        s_r <= '{dir: `EPM_RST_DIR, latch: `EPM_RST_LATCH, pin_out: `EPM_RST_LATCH,
                 pin_oe_n: ~`EPM_RST_DIR, irq15: `EPM_IDLE_LEVEL, trig: `EPM_IDLE_LEVEL,
                 rdata: 32'h00000000, waitreq: 1'b1}; // R09
    end
    else if (ce)
    begin
        s_r <= s_nxt;
    end
end

assign readdata = s_r.rdata;
assign waitrequest = s_r.waitreq;
assign pin_out = s_r.pin_out;
assign pin_oe_n = s_r.pin_oe_n;
assign conversion_trigger_input = s_r.trig;
assign ext_interrupt_15_input = s_r.irq15;

////////////////////////////////////////////////////////////////////////////////

default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);

chk_dir_write: assert property ((ce && write && !waitrequest && byteenable[0] && address == `EPM_OFS_DIR)
    |=> s_r.dir == $past(writedata[7:0])) // R01
    else $error("direction write lost");
chk_low_pins_enable: assert property (pin_oe_n[6:0] == ~s_r.dir[6:0]) // R02
    else $error("pin enable differs from direction");
chk_latch_drive: assert property (pin_out[6:0] == s_r.latch[6:0]) // R03
    else $error("pin output differs from latch");
chk_read_view: assert property ((ce && read && waitrequest && address == `EPM_OFS_LATCH)
    |=> !waitrequest && readdata[7:0] == port_view($past(s_r.latch), $past(s_r.dir), $past(pin_in))) // R04
    else $error("port read value wrong");
chk_tx_drive: assert property ((ce && tx_sel) |=> !pin_oe_n[7] && pin_out[7] == $past(serial_transmit_out)) // R05
    else $error("serial transmit not on pin 7");
chk_pin7_gpio: assert property ((ce && !tx_sel) |=> pin_oe_n[7] == !s_r.dir[7] && pin_out[7] == s_r.latch[7]) // R02
    else $error("pin 7 gpio drive wrong");
chk_trig_route: assert property ((ce && trg_sel) |=> conversion_trigger_input == $past(pin_in[7])) // R06
    else $error("trigger not routed");
chk_irq_route: assert property ((ce && irq15_source_select) |=> ext_interrupt_15_input == $past(pin_in[7])) // R07
    else $error("interrupt 15 not routed");
chk_irq_idle: assert property ((ce && !irq15_source_select) |=> ext_interrupt_15_input) // R07
    else $error("interrupt 15 not idle");
chk_reset_state: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |-> s_r.dir == 8'h00 && s_r.latch == 8'h00 && pin_oe_n == 8'hff) // R09
    else $error("reset state wrong");

cov_read_port: cover property (read && !waitrequest && address == `EPM_OFS_LATCH);
cov_tx_mode: cover property (tx_sel && !pin_oe_n[7]);
cov_irq_use: cover property (irq15_source_select && !s_r.dir[7]);
cov_mixed_dir: cover property (s_r.dir != 8'h00 && s_r.dir != 8'hff);

endmodule

/* test/epm_port_tb_top.sv */
// self-checking bench for the eight-bit port
`timescale 1ns/10ps
module epm_port_tb_top;
    logic core_clk = 0, rst = 0, ce = 1, read = 0, write = 0, waitrequest;
    logic conversion_trigger_input, ext_interrupt_15_input;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata;
    logic [7:0] pin_in = 8'h00, pin_out, pin_oe_n, rnd = 8'h5c, d, l;
    logic [6:0] sel = 7'h00;
    logic [11:0] tbl [6] = '{12'h0be, 12'h03c, 12'h0fd, 12'h505, 12'h70d, 12'h809};
    logic [31:0] exp_q [$];
    int miscompares = 0, cmp_count = 0, cyc = 0;
    always #2 core_clk = ~core_clk;
    epm_port u_epm_port (.core_clk(core_clk), .rst(rst), .ce(ce), .address(address), .byteenable(4'h1),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .serial_transmit_enable(sel[0]),
        .smart_card_select(sel[1]), .serial_transmit_out(sel[2]), .trigger_select_hi(sel[3]),
        .trigger_select_lo(sel[4]), .external_trigger_select(sel[5]), .irq15_source_select(sel[6]),
        .conversion_trigger_input(conversion_trigger_input), .ext_interrupt_15_input(ext_interrupt_15_input));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] nxt(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // request held until waitrequest is seen low, then released
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, v};
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, a, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk)
        if (read && waitrequest === 1'b0)
            chk(readdata, exp_q.pop_front());
    always @(posedge core_clk)
        if (++cyc > 2000)
        begin
            miscompares++;
            end_sim();
        end
    initial
    begin
        // rising edge at time zero so the asynchronous reset acts before the first clock
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(4'h4, 32'h0);
        chk({24'h0, pin_oe_n}, 32'hff);
        $display("test reset done");
        // random directions, latches and pin levels
        repeat (5)
        begin
            d = rnd;
            l = nxt(d);
            rnd = nxt(l);
            pin_in <= rnd;
            bus(1'b1, 4'h0, d);
            bus(1'b1, 4'h4, l);
            @(posedge core_clk);
            chk({24'h0, pin_oe_n}, {24'h0, ~d});
            chk({24'h0, pin_out & d}, {24'h0, l & d});
            rd(4'h4, {24'h0, (l & d) | (rnd & ~d)});
            rd(4'h0, 32'h0);
            rd(4'h8, 32'h0);
        end
        $display("test gpio done");
        bus(1'b1, 4'h0, 8'h00);
        bus(1'b1, 4'h4, 8'h00);
        // {selects, pin 7 level, expected trigger/interrupt/out7/oe7}
        foreach (tbl[i])
        begin
            sel <= tbl[i][11:5];
            pin_in[7] <= tbl[i][4];
            repeat (3) @(posedge core_clk);
            chk({28'h0, conversion_trigger_input, ext_interrupt_15_input, pin_out[7], pin_oe_n[7]},
                {28'h0, tbl[i][3:0]});
        end
        $display("test pin seven done");
        // clock enable low: transmit select must not reach pin 7
        ce <= 1'b0;
        sel <= 7'h01;
        repeat (3) @(posedge core_clk);
        chk({31'h0, pin_oe_n[7]}, 32'h1);
        ce <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({31'h0, pin_oe_n[7]}, 32'h0);
        $display("test clock enable done");
        end_sim();
    end
endmodule
